// file: core/spi_queue_cfg.svh
// Constants of the queued serial RAM block: map, fields, reset values, timing
// Function
// - Completed pointer moves only after full completion
// - Pointer keeps old value during first command
// - Eighty-byte RAM shared by bus and engine
// - Engine contention adds one or two waits
// - Byte/word/long access; aligned word indivisible
// - Bus part waits while the engine fetches or stores
// - Long or split access done in two parts
// - RAM holds receive, transmit and command regions
// - Queue runs alone, then sets finished flag
// - Receive words stored right-aligned from bit zero
// - Receive bits above length cleared on completion
// - Engine never writes the transmit region
// - Command bytes read in master only, unmodified
// - Command byte fields: hold, length, delays, selects; the code ignores both delay bits
// - Entries run in order from first to last
// - Select pattern bits driven directly onto pins
// - Pin data sets idle and unassigned selects
// - Hold zero returns selects to pin data
// - Hold one, same pattern: selects stay driven
// - Hold one, new pattern: old kept until switch
// - Completion compares pointer with last entry
// - Bus writes cannot change completed pointer
`ifndef SPI_QUEUE_CFG_SVH
`define SPI_QUEUE_CFG_SVH

`define RAM_BYTES       80
`define RX_BASE         0
`define TX_BASE         32
`define CMD_BASE        64
`define ADR_CTRL        8'h80
`define ADR_PINS        8'h84
`define ADR_STATUS      8'h88

`define CMD_HOLD        7
`define CMD_LEN_SEL     6
`define CMD_POST_DLY    5
`define CMD_SEL_DLY     4

`define PCS_OE_N_RST    4'hf
`define LEN_DEFAULT     5'h08

`define CLK_NS          10
`define SCK_HALF_NS     80
`define SCK_HALF_CYC    (`SCK_HALF_NS / `CLK_NS)

`endif

// file: core/spi_queue_pkg.sv
// Types of the queued serial RAM block
package spi_queue_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_FETCH = 3'b001,
        ST_SETUP = 3'b010,
        ST_SHIFT = 3'b011,
        ST_STORE = 3'b100
    } eng_state_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic       enable;
        logic       wrap;
        logic [3:0] first;
        logic [3:0] last;
        logic [3:0] bits;
    } queue_ctrl_t;

    typedef struct packed {
        logic [3:0] data;
        logic [3:0] assign_q;
        logic [3:0] dir;
    } pin_regs_t;

    typedef struct packed {
        logic [79:0][7:0] mem;
        queue_ctrl_t      ctrl;
        pin_regs_t        pins;
        logic             finished;
        logic [3:0]       cpt;
        logic             jump;
        eng_state_t       st;
        logic [3:0]       ptr;
        logic [7:0]       cmd;
        logic [4:0]       len;
        logic [15:0]      sh;
        logic [15:0]      rx;
        logic [3:0]       div;
        logic [4:0]       bitn;
        logic             sck;
        logic             mosi;
        logic             sel_on;
        logic [3:0]       pat;
        logic             miso1;
        logic             miso2;
        logic [1:0]       part;
        logic             ack;
        logic [31:0]      rdat;
        logic [3:0]       pcs;
        logic [3:0]       pcs_oe_n;
    } core_state_t;

endpackage : spi_queue_pkg

// file: core/spi_queue_ram.sv
// Queued serial master: shared queue RAM, Wishbone slave and select pin control
`timescale 1ns/10ps
`default_nettype none
`include "spi_queue_cfg.svh"

module spi_queue_ram #(
    parameter int SCK_HALF = `SCK_HALF_CYC
) (
    input  wire logic                    clk_sys,  // System clock
    input  wire logic                    rst,      // Synchronous reset
    input  wire spi_queue_pkg::wb_req_t  wb_i,     // Wishbone request
    output var  logic [31:0]             wb_dat_o, // Wishbone read data
    output var  logic                    wb_ack_o, // Wishbone acknowledge
    output var  logic                    sck_o,    // Serial clock
    output var  logic                    mosi_o,   // Serial data out
    input  wire logic                    miso_i,   // Serial data in
    output var  logic [3:0]              pcs_o,    // Select pin levels
    output var  logic [3:0]              pcs_oe_n  // Select pin drive, low drives
);

    if (SCK_HALF < 1 || SCK_HALF > 16) begin : g_chk
        $error("SCK_HALF must lie in 1..16");
    end

    spi_queue_pkg::core_state_t s;
    spi_queue_pkg::core_state_t next_s;

    logic       req;
    logic       in_ram;
    logic       eng_ram;
    logic [1:0] need;
    logic [6:0] base;

    assign req     = wb_i.cyc && wb_i.stb && !s.ack;
    assign in_ram  = wb_i.adr < 8'(`RAM_BYTES);
    // Engine owns the RAM for one whole cycle in fetch and store
    assign eng_ram = (s.st == spi_queue_pkg::ST_FETCH) ||
                     (s.st == spi_queue_pkg::ST_STORE);
    assign need    = {|wb_i.sel[3:2], |wb_i.sel[1:0]};
    assign base    = {wb_i.adr[6:2], 2'b00};

    always_comb begin
        logic [6:0]  a;
        logic        pick;
        logic        half;
        logic [15:0] tx;
        logic [16:0] mask;
        logic [15:0] rxm;
        logic [4:0]  blen;
        logic        jreq;
        jreq = 1'b0;
        a    = 7'h00;
        pick = 1'b0;
        half = 1'b0;
        tx   = 16'h0000;
        mask = 17'h00000;
        rxm  = 16'h0000;
        blen = 5'h00;
        next_s       = s;
        next_s.miso1 = miso_i;
        next_s.miso2 = s.miso1;
        next_s.ack   = 1'b0;

        // Bus side
        if (req && in_ram) begin
            // An access is split into halfword parts; each part is a single
            // RAM cycle, so the engine can slip in only between parts
            if (!eng_ram) begin
                if (need[0] && !s.part[0]) begin
                    pick = 1'b1;
                    half = 1'b0;
                end else if (need[1] && !s.part[1]) begin
                    pick = 1'b1;
                    half = 1'b1;
                end
            end
            if (pick) begin
                next_s.part[half] = 1'b1;
                for (int k = 0; k < 2; k++) begin
                    a = base + 7'({half, 1'b0}) + 7'(k);
                    if (wb_i.we && wb_i.sel[{half, 1'(k)}]) begin
                        next_s.mem[a] = wb_i.dat[{half, 1'(k), 3'b000} +: 8];
                    end
                end
            end
            if ((next_s.part | ~need) == 2'b11) begin
                next_s.ack  = 1'b1;
                next_s.part = 2'b00;
                // Read data moves only with ack, so it stands until the next answer
                for (int k = 0; k < 4; k++) begin
                    next_s.rdat[8*k +: 8] = s.mem[base + 7'(k)];
                end
            end
        end else if (req) begin
            next_s.ack  = 1'b1;
            next_s.rdat = 32'h00000000;
            case (wb_i.adr & 8'hfc)
                `ADR_CTRL: begin
                    next_s.rdat = {16'h0000, s.ctrl.bits, s.ctrl.last,
                                   s.ctrl.first, 2'b00, s.ctrl.wrap, s.ctrl.enable};
                    if (wb_i.we && wb_i.sel[0]) begin
                        next_s.ctrl.enable = wb_i.dat[0];
                        next_s.ctrl.wrap   = wb_i.dat[1];
                        next_s.ctrl.first  = wb_i.dat[7:4];
                        if (s.st != spi_queue_pkg::ST_IDLE &&
                            wb_i.dat[7:4] != s.ctrl.first) begin
                            next_s.jump = 1'b1;
                            jreq        = 1'b1;
                        end
                    end
                    if (wb_i.we && wb_i.sel[1]) begin
                        next_s.ctrl.last = wb_i.dat[11:8];
                        next_s.ctrl.bits = wb_i.dat[15:12];
                    end
                end
                `ADR_PINS: begin
                    next_s.rdat = {12'h000, s.pins.dir, 4'h0, s.pins.assign_q,
                                   4'h0, s.pins.data};
                    if (wb_i.we && wb_i.sel[0]) begin
                        next_s.pins.data = wb_i.dat[3:0];
                    end
                    if (wb_i.we && wb_i.sel[1]) begin
                        next_s.pins.assign_q = wb_i.dat[11:8];
                    end
                    if (wb_i.we && wb_i.sel[2]) begin
                        next_s.pins.dir = wb_i.dat[19:16];
                    end
                end
                `ADR_STATUS: begin
                    next_s.rdat = {23'h000000, s.st != spi_queue_pkg::ST_IDLE,
                                   s.cpt, 3'b000, s.finished};
                    // Only the flag clears here; the pointer field is read-only
                    if (wb_i.we && wb_i.sel[0] && !wb_i.dat[0]) begin
                        next_s.finished = 1'b0;
                    end
                end
                default: begin
                    next_s.rdat = 32'h00000000;
                end
            endcase
        end

        // Serial engine
        case (s.st)
            spi_queue_pkg::ST_IDLE: begin
                next_s.sck    = 1'b0;
                next_s.sel_on = 1'b0;
                if (s.ctrl.enable) begin
                    next_s.st   = spi_queue_pkg::ST_FETCH;
                    next_s.ptr  = s.ctrl.first;
                    next_s.jump = 1'b0;
                end
            end
            spi_queue_pkg::ST_FETCH: begin
                // Command and transmit bytes are only read here
                next_s.cmd = s.mem[7'(`CMD_BASE) + 7'(s.ptr)];
                tx = {s.mem[7'(`TX_BASE) + {2'b00, s.ptr, 1'b1}],
                      s.mem[7'(`TX_BASE) + {2'b00, s.ptr, 1'b0}]};
                blen = (s.ctrl.bits == 4'h0) ? 5'h10 :
                       (s.ctrl.bits < 4'h8) ? `LEN_DEFAULT : {1'b0, s.ctrl.bits};
                next_s.len = next_s.cmd[`CMD_LEN_SEL] ? blen : `LEN_DEFAULT;
                next_s.sh     = tx << (5'h10 - next_s.len);
                next_s.rx     = 16'h0000;
                next_s.div    = 4'h0;
                next_s.bitn   = 5'h00;
                // With hold set the old pattern is kept up to this switch
                next_s.pat    = next_s.cmd[3:0];
                next_s.sel_on = 1'b1;
                next_s.st     = spi_queue_pkg::ST_SETUP;
            end
            spi_queue_pkg::ST_SETUP: begin
                next_s.mosi = s.sh[15];
                next_s.div  = s.div + 4'h1;
                if (s.div == 4'(SCK_HALF - 1)) begin
                    next_s.div = 4'h0;
                    next_s.st  = spi_queue_pkg::ST_SHIFT;
                end
            end
            spi_queue_pkg::ST_SHIFT: begin
                next_s.div = s.div + 4'h1;
                if (s.div == 4'(SCK_HALF - 1)) begin
                    next_s.div = 4'h0;
                    next_s.sck = !s.sck;
                    if (!s.sck) begin
                        // Shift in from the bottom keeps the word right-aligned
                        next_s.rx = {s.rx[14:0], s.miso2};
                    end else if (s.bitn == s.len - 5'h01) begin
                        next_s.st = spi_queue_pkg::ST_STORE;
                    end else begin
                        next_s.bitn = s.bitn + 5'h01;
                        next_s.sh   = {s.sh[14:0], 1'b0};
                        next_s.mosi = s.sh[14];
                    end
                end
            end
            spi_queue_pkg::ST_STORE: begin
                mask = (17'h00001 << s.len) - 17'h00001;
                rxm  = s.rx & mask[15:0];
                next_s.mem[7'(`RX_BASE) + {2'b00, s.ptr, 1'b0}] = rxm[7:0];
                next_s.mem[7'(`RX_BASE) + {2'b00, s.ptr, 1'b1}] = rxm[15:8];
                // Pointer moves in the same cycle as the receive word lands
                next_s.cpt    = s.ptr;
                next_s.sel_on = s.cmd[`CMD_HOLD];
                if (s.ptr == s.ctrl.last) begin
                    next_s.finished = 1'b1;
                    if (s.ctrl.wrap) begin
                        next_s.ptr = s.ctrl.first;
                        next_s.st  = spi_queue_pkg::ST_FETCH;
                    end else begin
                        next_s.ctrl.enable = 1'b0;
                        next_s.st          = spi_queue_pkg::ST_IDLE;
                    end
                end else begin
                    next_s.ptr = s.jump ? s.ctrl.first : s.ptr + 4'h1;
                    next_s.st  = spi_queue_pkg::ST_FETCH;
                end
                // A first-pointer write in this very cycle must not be lost
                next_s.jump = jreq;
            end
            default: begin
                next_s.st = spi_queue_pkg::ST_IDLE;
            end
        endcase

        // Disabling stops at once, except that a store finishes first; the pins fall back to pin data
        if (!s.ctrl.enable && s.st != spi_queue_pkg::ST_IDLE &&
            s.st != spi_queue_pkg::ST_STORE) begin
            next_s.st     = spi_queue_pkg::ST_IDLE;
            next_s.sck    = 1'b0;
            next_s.sel_on = 1'b0;
        end

        // Select pins: one cycle behind the engine, always from flops
        for (int i = 0; i < 4; i++) begin
            next_s.pcs[i] = (s.ctrl.enable && s.pins.assign_q[i] && s.sel_on) ?
                            s.pat[i] : s.pins.data[i];
        end
        next_s.pcs_oe_n = ~s.pins.dir;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s          <= '0;
            s.pcs_oe_n <= `PCS_OE_N_RST;
        end else begin
            s <= next_s;
        end
    end

    assign wb_dat_o = s.rdat;
    assign wb_ack_o = s.ack;
    assign sck_o    = s.sck;
    assign mosi_o   = s.mosi;
    assign pcs_o    = s.pcs;
    assign pcs_oe_n = s.pcs_oe_n;

endmodule : spi_queue_ram
`default_nettype wire

// file: verif/spi_queue_ram_properties.sv
// Port checker for the queued serial RAM block
`timescale 1ns/10ps
`default_nettype none
module spi_queue_ram_checker #(
    parameter int SCK_HALF = 8
) (
    input wire logic                   clk_sys,  // System clock
    input wire logic                   rst,      // Reset
    input wire spi_queue_pkg::wb_req_t wb_i,     // Bus request
    input wire logic [31:0]            wb_dat_o, // Read data
    input wire logic                   wb_ack_o, // Acknowledge
    input wire logic                   sck_o,    // Serial clock
    input wire logic                   mosi_o,   // Serial out
    input wire logic                   miso_i,   // Serial in
    input wire logic [3:0]             pcs_o,    // Select levels
    input wire logic [3:0]             pcs_oe_n  // Select drive
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_ack_bounded: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |-> ##[1:4] wb_ack_o)
        else $error("ack later than four cycles");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (wb_ack_o |-> $past(wb_i.cyc && wb_i.stb))
        else $error("ack without request");
    chk_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
        else $error("read data moved without ack");
    chk_pins_reset: assert property ($fell(rst) |-> pcs_oe_n == 4'hf && pcs_o == 4'h0)
        else $error("select pins not idle after reset");
    // Drive enables come only from direction writes, never from the engine
    chk_oe_by_write: assert property ($changed(pcs_oe_n) |->
            $past(wb_i.cyc && wb_i.we) || $past(wb_i.cyc && wb_i.we, 2))
        else $error("select drive changed without a write");
    chk_pcs_steady: assert property (sck_o |-> $stable(pcs_o))
        else $error("selects moved while clock high");
    chk_mosi_steady: assert property (sck_o |-> $stable(mosi_o))
        else $error("data out moved while clock high");
endmodule : spi_queue_ram_checker

bind spi_queue_ram spi_queue_ram_checker #(.SCK_HALF(SCK_HALF)) i_spi_queue_ram_checker (
    .clk_sys(clk_sys), .rst(rst), .wb_i(wb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sck_o(sck_o), .mosi_o(mosi_o), .miso_i(miso_i), .pcs_o(pcs_o), .pcs_oe_n(pcs_oe_n));
`default_nettype wire

// file: verif/spi_periph_model.sv
// Serial peripheral on select pin 0, mode 0, answers a fixed word
`timescale 1ns/10ps
`default_nettype none
module spi_periph_model #(
    parameter logic [15:0] REPLY = 16'hc5a3
) (
    input  wire logic        sck,   // Serial clock
    input  wire logic        sel_n, // Select, low active
    input  wire logic        mosi,  // Data from master
    output var  logic        miso,  // Data to master
    output var  logic [15:0] got    // Bits seen since select
);
    logic [15:0] sh;
    initial miso = 1'b0;
    always @(negedge sel_n) begin
        sh = REPLY;
        got = 16'h0;
        miso = sh[15];
    end
    // No pull-up on the line: a released driver must not look like valid data
    always @(posedge sel_n) miso = ~miso;
    always @(posedge sck) if (!sel_n) got = {got[14:0], mosi};
    always @(negedge sck) if (!sel_n) begin
        sh = sh << 1;
        miso = sh[15];
    end
endmodule : spi_periph_model
`default_nettype wire

// file: verif/spi_queue_ram_test.sv
// Self-checking bench for the queued serial RAM block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module spi_queue_ram_test;
    logic                   clk_sys;
    logic                   rst;
    spi_queue_pkg::wb_req_t wb_i;
    logic [31:0]            wb_dat_o;
    logic                   wb_ack_o;
    logic                   sck_o;
    logic                   mosi_o;
    logic                   miso;
    logic [3:0]             pcs_o;
    logic [3:0]             pcs_oe_n;
    logic [15:0]            got;
    logic [31:0]            q;
    int                     num_errors;
    int                     cmp_count;

    spi_queue_ram #(.SCK_HALF(8)) i_spi_queue_ram (.clk_sys(clk_sys), .rst(rst), .wb_i(wb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sck_o(sck_o), .mosi_o(mosi_o),
        .miso_i(miso), .pcs_o(pcs_o), .pcs_oe_n(pcs_oe_n));
    spi_periph_model i_spi_periph_model (.sck(sck_o), .sel_n(pcs_o[0] | pcs_oe_n[0]),
        .mosi(mosi_o), .miso(miso), .got(got));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic conclude();
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude

    // One classic cycle; the ack is read at the edge, before that edge's updates land
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] lanes = 4'hf);
        int n;
        n = 0;
        wb_i <= '{1'b1, 1'b1, w, lanes, a, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        if (n >= 40) num_errors++;
        q = wb_dat_o;
        wb_i <= '0;
        @(posedge clk_sys);
    endtask : xfer

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask : rdc

    task automatic wait_done();
        for (int n = 0; n < 500; n++) begin
            // A command read while the engine runs; its seven-cycle rhythm meets the second store and the fetch after it, which add two waits
            xfer(1'b0, 8'h40, 32'h0);
            `CHK(q, 32'h4e4c_8e0e)
            xfer(1'b0, 8'h88, 32'h0);
            if (q[0] === 1'b1) break;
        end
        `CHK(q[0], 1'b1)
    endtask : wait_done

    initial begin
        #300us;
        num_errors++;
        conclude();
    end

    initial begin
        wb_i = '0;
        rst = 1'b1;
        num_errors = 0;
        cmp_count = 0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rdc(8'h88, 32'h0);
        xfer(1'b1, 8'h4c, 32'h1234_5678);
        xfer(1'b1, 8'h4c, 32'h0000_ab00, 4'h2);
        rdc(8'h4c, 32'h1234_ab78);
        xfer(1'b1, 8'h50, 32'hffff_ffff);
        rdc(8'h50, 32'h0);
        xfer(1'b1, 8'h84, 32'h0000_030f);
        repeat (2) @(posedge clk_sys);
        `CHK(pcs_oe_n, 4'hf)
        xfer(1'b1, 8'h84, 32'h0003_030f);
        repeat (2) @(posedge clk_sys);
        `CHK(pcs_oe_n, 4'hc)
        `CHK(pcs_o, 4'hf)
        xfer(1'b1, 8'h00, 32'hffff_ffff);
        xfer(1'b1, 8'h04, 32'hffff_ffff);
        xfer(1'b1, 8'h20, 32'h003c_00a5);
        xfer(1'b1, 8'h24, 32'h0081_0f0f);
        xfer(1'b1, 8'h40, 32'h4e4c_8e0e);
        xfer(1'b1, 8'h80, 32'h0000_c201);
        wait_done();
        rdc(8'h00, 32'h00c5_00c5);
        rdc(8'h04, 32'hffff_0a30);
        rdc(8'h88, 32'h0000_0021);
        rdc(8'h80, 32'h0000_c200);
        rdc(8'h20, 32'h003c_00a5);
        rdc(8'h40, 32'h4e4c_8e0e);
        `CHK(got, 16'hcf0f)
        `CHK(pcs_o, 4'hf)
        xfer(1'b1, 8'h88, 32'h0000_00f0);
        rdc(8'h88, 32'h0000_0020);
        xfer(1'b1, 8'h80, 32'h0000_0331);
        rdc(8'h88, 32'h0000_0120);
        wait_done();
        rdc(8'h04, 32'hc5a3_0a30);
        `CHK(got, 16'h0081)
        rdc(8'h88, 32'h0000_0031);
        conclude();
    end
endmodule : spi_queue_ram_test
`default_nettype wire
